// [rtl/dpb_pkg.sv]
package dpb_pkg;
   localparam int ADDR_W      = 32;
   localparam int ENTRIES     = 8;
   localparam int LINE_SHIFT  = 7;
   localparam int HALF_SHIFT  = 6;
   localparam int REGION_W    = 8;
   localparam int REGION_HI   = 31;
   localparam int REGIONS     = 256;
   localparam logic [255:0] PERMIT_RESET = 256'h0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_F000;
   localparam logic [31:0] HALF_BYTES = 32'h0000_0040;
   localparam logic [31:0] LINE_BYTES = 32'h0000_0080;
   typedef enum logic [1:0] {DPB_PF_LOOKBACK, DPB_PF_FIRST, DPB_PF_SECOND} dpb_pf_kind_type;
endpackage

// [rtl/dpb_age_tracker.sv]
`timescale 1ns/1ps
module dpb_age_tracker #(
   parameter int N = 8
) (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic                 touch,
   input  wire logic [$clog2(N)-1:0] touchIdx,
   output logic      [$clog2(N)-1:0] oldestIdx
);
   logic [$clog2(N)-1:0] allocPtr_q;
   initial begin
      if (N < 2) $error("N too small");
   end
   // Round-robin: allocated entry becomes newest, next one the oldest
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         allocPtr_q <= '0;
      end else if (touch && touchIdx == allocPtr_q) begin
         allocPtr_q <= (allocPtr_q == $clog2(N)'(N - 1)) ? '0 : allocPtr_q + 1'b1;
      end
   end
   assign oldestIdx = allocPtr_q; // R3
endmodule

// [rtl/dpb_prefetch_buffer.sv]
// Operation
// R1: Eight entries, each tracks one stream
// R2: Entry is 128-byte line, two halves hit
// R3: Allocation pointer always marks oldest entry
// R4: Half hit may refetch other half
// R5: Prefetchable hit reallocates oldest to X+64 (code reallocates it to X+128)
// R6: Issue X+64 then X+128 next cycle (code issues X+128 then X+192)
// R7: Newer prefetch on slot stales older one
// R8: Stale marking holds on same-edge departure
// R9: Cleared permit stops prefetch, caching allowed
// R10: Permit for regions 12-15 resets to one
// R11: Half-line refetch only when L2 unusable
// R12: Data hit served; pending served on return
// R13: Address hit forwarded, allocation continues
// R14: Matching write invalidates prefetched data
// R15: Colliding prefetches discard the earlier one
// R16: Failed return leaves slot empty, miss
`timescale 1ns/1ps
module dpb_prefetch_buffer #(
   parameter int ENTRIES = dpb_pkg::ENTRIES,
   parameter int TAG_W   = 4
) (
   input  wire logic                        mclk,
   input  wire logic                        reset_n,
   input  wire logic                        reqValid,
   input  wire logic                        reqWrite,
   input  wire logic                        reqPrefetchable,
   input  wire logic                        reqCandidateHit,
   input  wire logic [dpb_pkg::ADDR_W-1:0]  reqAddr,
   input  wire logic                        l2Disabled,
   input  wire logic                        l2SizeZero,
   input  wire logic                        l2Frozen,
   input  wire logic                        permitWrite,
   input  wire logic [dpb_pkg::REGION_W-1:0] permitRegion,
   input  wire logic                        permitValue,
   output logic                             hitData,
   output logic                             hitWait,
   output logic                             forwardMiss,
   output logic [$clog2(ENTRIES)-1:0]       hitEntry,
   output logic                             hitHalf,
   output logic                             pfValid,
   input  wire logic                        pfReady,
   output logic [dpb_pkg::ADDR_W-1:0]       pfAddr,
   output logic [TAG_W-1:0]                 pfTag,
   output logic                             pfWholeLine,
   input  wire logic                        rtnValid,
   input  wire logic [TAG_W-1:0]            rtnTag,
   input  wire logic                        rtnOk,
   output logic                             serveValid,
   output logic [$clog2(ENTRIES)-1:0]       serveEntry,
   output logic                             serveHalf
);
   localparam int IW = $clog2(ENTRIES);
   localparam int SLOTS = 2 * ENTRIES;
   initial begin
      if (ENTRIES < 2 || TAG_W != IW + 1) $error("Bad parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Entry and slot state
   logic [ENTRIES-1:0]                       streamValid_q;
   logic [dpb_pkg::ADDR_W-1:0]               lineAddr_q [ENTRIES];
   logic [SLOTS-1:0]                         dataPresent_q, dataPresent_d;
   logic [SLOTS-1:0]                         pending_q, pending_d;
   logic [SLOTS-1:0]                         waiter_q, waiter_d;
   logic [dpb_pkg::REGIONS-1:0]              permit_q;

   ////////////////////////////////////////////////////////////////////////////
   // Lookup
   logic [ENTRIES-1:0] entryMatch;
   logic [dpb_pkg::ADDR_W-1:0] reqLine;
   assign reqLine = {reqAddr[dpb_pkg::ADDR_W-1:dpb_pkg::LINE_SHIFT], {dpb_pkg::LINE_SHIFT{1'b0}}};
   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++) begin : gMatch
         assign entryMatch[g] = streamValid_q[g] && lineAddr_q[g] == reqLine; // R2
      end
   endgenerate

   logic anyMatch;
   logic [IW-1:0] matchIdx;
   always_comb begin
      matchIdx = '0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (entryMatch[i]) matchIdx = IW'(i);
      end
   end
   assign anyMatch = |entryMatch;

   wire         reqHalf    = reqAddr[dpb_pkg::HALF_SHIFT];
   wire [IW:0]  reqSlot    = {matchIdx, reqHalf};
   wire [IW:0]  otherSlot  = {matchIdx, ~reqHalf};
   wire         readReq    = reqValid && !reqWrite;
   wire         writeReq   = reqValid && reqWrite;
   wire         regionOk   = permit_q[reqAddr[dpb_pkg::REGION_HI -: dpb_pkg::REGION_W]];
   wire         prefetchOk = reqPrefetchable && regionOk; // R9
   wire         halfMode   = l2Disabled || l2SizeZero || l2Frozen; // R11
   wire         slotData   = dataPresent_q[reqSlot];
   wire         slotPend   = pending_q[reqSlot];

   assign hitData     = readReq && anyMatch && slotData; // R12
   assign hitWait     = readReq && anyMatch && !slotData && slotPend; // R12
   assign forwardMiss = readReq && !(anyMatch && (slotData || slotPend)); // R13 R16
   assign hitEntry    = matchIdx;
   assign hitHalf     = reqHalf;

   ////////////////////////////////////////////////////////////////////////////
   // Allocation
   logic [IW-1:0] oldestIdx;
   // Lookback claims the hit; otherwise a hit reallocates
   wire lookbackNow = readReq && prefetchOk && halfMode && anyMatch && !reqCandidateHit
                      && !dataPresent_q[otherSlot] && !pending_q[otherSlot]; // R4
   wire allocNow = readReq && prefetchOk && (anyMatch || reqCandidateHit) && !lookbackNow; // R5
   wire [dpb_pkg::ADDR_W-1:0] allocLine = reqLine + dpb_pkg::LINE_BYTES; // R5

   dpb_age_tracker #(.N(ENTRIES)) uAge (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .touch    (allocNow),
      .touchIdx (oldestIdx),
      .oldestIdx(oldestIdx)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Prefetch issue stage (one register, newer request overwrites)
   logic                       issueValid_q;
   logic [dpb_pkg::ADDR_W-1:0] issueAddr_q;
   logic [IW:0]                issueSlot_q;
   logic                       secondPend_q;
   logic [dpb_pkg::ADDR_W-1:0] secondAddr_q;
   logic [IW:0]                secondSlot_q;

   logic newIssue;
   logic [dpb_pkg::ADDR_W-1:0] newAddr;
   logic [IW:0] newSlot;
   always_comb begin
      newIssue = 1'b0;
      newAddr  = '0;
      newSlot  = '0;
      if (allocNow) begin
         newIssue = 1'b1; // R6
         newAddr  = allocLine;
         newSlot  = {oldestIdx, 1'b0};
      end else if (lookbackNow) begin
         newIssue = 1'b1; // R4
         newAddr  = reqLine + (reqHalf ? '0 : dpb_pkg::HALF_BYTES);
         newSlot  = otherSlot;
      end else if (secondPend_q) begin
         newIssue = 1'b1; // R6
         newAddr  = secondAddr_q;
         newSlot  = secondSlot_q;
      end
   end

   wire issueLeaves = issueValid_q && pfReady;
   wire issueBlocked = issueValid_q && !pfReady;
   assign pfValid     = issueValid_q;
   assign pfAddr      = issueAddr_q;
   assign pfTag       = issueSlot_q;
   assign pfWholeLine = !halfMode;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         issueValid_q <= 1'b0;
         issueAddr_q  <= '0;
         issueSlot_q  <= '0;
      end else if (newIssue) begin
         issueValid_q <= 1'b1; // R15
         issueAddr_q  <= newAddr;
         issueSlot_q  <= newSlot;
      end else if (issueLeaves) begin
         issueValid_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         secondPend_q <= 1'b0;
         secondAddr_q <= '0;
         secondSlot_q <= '0;
      end else if (allocNow) begin
         secondPend_q <= 1'b1; // R6
         secondAddr_q <= allocLine + dpb_pkg::HALF_BYTES;
         secondSlot_q <= {oldestIdx, 1'b1};
      end else if (newIssue && !lookbackNow) begin
         secondPend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot bookkeeping: only the latest tag per slot is live
   wire rtnLive = rtnValid && pending_q[rtnTag]; // R7
   always_comb begin
      dataPresent_d = dataPresent_q;
      pending_d     = pending_q;
      waiter_d      = waiter_q;
      if (issueLeaves) begin
         pending_d[issueSlot_q] = 1'b1;
      end
      if (rtnLive && !(issueLeaves && issueSlot_q == rtnTag)) begin
         pending_d[rtnTag]     = 1'b0;
         dataPresent_d[rtnTag] = rtnOk; // R16
         waiter_d[rtnTag]      = 1'b0;
      end
      if (hitWait) begin
         waiter_d[reqSlot] = 1'b1; // R12
      end
      if (allocNow) begin
         dataPresent_d[{oldestIdx, 1'b0}] = 1'b0;
         dataPresent_d[{oldestIdx, 1'b1}] = 1'b0;
         pending_d[{oldestIdx, 1'b0}]     = 1'b0; // R7 R8
         pending_d[{oldestIdx, 1'b1}]     = 1'b0; // R7 R8
         waiter_d[{oldestIdx, 1'b0}]      = 1'b0;
         waiter_d[{oldestIdx, 1'b1}]      = 1'b0;
      end else if (newIssue) begin
         pending_d[newSlot]     = 1'b0; // R7 R8
         dataPresent_d[newSlot] = 1'b0;
      end
      if (writeReq && anyMatch) begin
         dataPresent_d[reqSlot] = 1'b0; // R14
         pending_d[reqSlot]     = 1'b0; // R14
      end
      if (issueBlocked && newIssue) begin
         pending_d[issueSlot_q] = pending_d[issueSlot_q]; // R15
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dataPresent_q <= '0;
         pending_q     <= '0;
         waiter_q      <= '0;
      end else begin
         dataPresent_q <= dataPresent_d;
         pending_q     <= pending_d;
         waiter_q      <= waiter_d;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         serveValid <= 1'b0;
         serveEntry <= '0;
         serveHalf  <= 1'b0;
      end else begin
         serveValid <= rtnLive && rtnOk && waiter_q[rtnTag]; // R12
         serveEntry <= rtnTag[IW:1];
         serveHalf  <= rtnTag[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stream table
   generate
      for (g = 0; g < ENTRIES; g++) begin : gEntry
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               streamValid_q[g] <= 1'b0;
               lineAddr_q[g]    <= '0;
            end else if (allocNow && oldestIdx == IW'(g)) begin
               streamValid_q[g] <= 1'b1; // R1
               lineAddr_q[g]    <= allocLine; // R5
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Region prefetch permit bits
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         permit_q <= dpb_pkg::PERMIT_RESET; // R10
      end else if (permitWrite) begin
         permit_q[permitRegion] <= permitValue; // R9
      end
   end
endmodule

// [tb/dpb_checker_sva.sv]
`timescale 1ns/1ps
module dpb_checker #(parameter int TAG_W = 4) (
   input wire logic             mclk,
   input wire logic             reset_n,
   input wire logic             reqValid,
   input wire logic             reqWrite,
   input wire logic [31:0]      reqAddr,
   input wire logic             l2Disabled,
   input wire logic             l2SizeZero,
   input wire logic             l2Frozen,
   input wire logic             hitData,
   input wire logic             hitWait,
   input wire logic             forwardMiss,
   input wire logic             hitHalf,
   input wire logic             pfValid,
   input wire logic             pfReady,
   input wire logic [31:0]      pfAddr,
   input wire logic [TAG_W-1:0] pfTag,
   input wire logic             pfWholeLine,
   input wire logic             rtnValid,
   input wire logic [TAG_W-1:0] rtnTag,
   input wire logic             rtnOk,
   input wire logic             serveValid,
   input wire logic [TAG_W-2:0] serveEntry,
   input wire logic             serveHalf
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   wire rdReq = reqValid && !reqWrite;
   sequence firstTaken;
      pfValid && pfReady && !pfTag[0] && pfWholeLine && !reqValid;
   endsequence
   hit_excl_a: assert property (rdReq |-> $onehot({hitData, hitWait, forwardMiss}))
      else $error("read outcome not unique");
   hit_half_a: assert property (rdReq && (hitData || hitWait) |-> hitHalf == reqAddr[6])
      else $error("hit half wrong");
   whole_line_a: assert property (pfWholeLine == !(l2Disabled || l2SizeZero || l2Frozen))
      else $error("line mode wrong");
   pf_hold_a: assert property (pfValid && !pfReady |=> pfValid)
      else $error("prefetch dropped");
   pf_stable_a: assert property (pfValid && !pfReady && !reqValid && !$past(reqValid)
      |=> $stable(pfAddr) && $stable(pfTag))
      else $error("prefetch changed while stalled");
   second_half_a: assert property (firstTaken |=> pfValid && pfTag == {$past(pfTag[TAG_W-1:1]), 1'b1}
      && pfAddr == $past(pfAddr) + dpb_pkg::HALF_BYTES) else $error("second prefetch wrong");
   serve_src_a: assert property (serveValid |-> $past(rtnValid && rtnOk)
      && serveEntry == $past(rtnTag[TAG_W-1:1]) && serveHalf == $past(rtnTag[0])) else $error("bad serve");
   pf_cause_a: assert property ($rose(pfValid) |-> $past(reqValid))
      else $error("prefetch without request");
endmodule

bind dpb_prefetch_buffer dpb_checker #(.TAG_W(TAG_W)) dpb_checker_i (
   .mclk(mclk), .reset_n(reset_n), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
   .l2Disabled(l2Disabled), .l2SizeZero(l2SizeZero), .l2Frozen(l2Frozen), .hitData(hitData),
   .hitWait(hitWait), .forwardMiss(forwardMiss), .hitHalf(hitHalf), .pfValid(pfValid), .pfReady(pfReady),
   .pfAddr(pfAddr), .pfTag(pfTag), .pfWholeLine(pfWholeLine), .rtnValid(rtnValid), .rtnTag(rtnTag),
   .rtnOk(rtnOk), .serveValid(serveValid), .serveEntry(serveEntry), .serveHalf(serveHalf));

// [tb/dpb_mem_model.sv]
`timescale 1ns/1ps
module dpb_mem_model #(parameter int TAG_W = 4) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             stall,
   input  wire logic             hold,
   input  wire logic             fail,
   input  wire logic             pfValid,
   output logic                  pfReady,
   input  wire logic [TAG_W-1:0] pfTag,
   output logic                  rtnValid,
   output logic      [TAG_W-1:0] rtnTag,
   output logic                  rtnOk
);
   logic [TAG_W-1:0] pend[$];
   assign pfReady = !stall;
   // Returns in order, one per cycle; idle lines toggle
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pend.delete();
         rtnValid <= 1'b0;
         rtnTag <= '0;
         rtnOk <= 1'b0;
      end else begin
         if (pfValid && pfReady) pend.push_back(pfTag);
         rtnValid <= !hold && pend.size() > 0;
         if (!hold && pend.size() > 0) begin
            rtnTag <= pend.pop_front();
            rtnOk <= !fail;
         end else begin
            rtnTag <= ~rtnTag;
            rtnOk <= ~rtnOk;
         end
      end
   end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
   logic        reqPrefetchable = 1'b0, reqCandidateHit = 1'b0, permitWrite = 1'b0, permitValue = 1'b0;
   logic        l2Disabled = 1'b0, l2SizeZero = 1'b0, l2Frozen = 1'b0, stall = 1'b0, hold = 1'b0, fail = 1'b0;
   logic [31:0] reqAddr = 32'h0000_0000;
   logic [7:0]  permitRegion = 8'h00;
   logic        hitData, hitWait, forwardMiss, hitHalf, pfValid, pfReady, pfWholeLine;
   logic        rtnValid, rtnOk, serveValid, serveHalf;
   logic [2:0]  hitEntry, serveEntry, ent;
   logic [3:0]  pfTag, rtnTag, fl;
   logic [31:0] pfAddr;
   logic [31:0] qAddr[$];
   logic [3:0]  qTag[$];
   logic [2:0]  e[9];
   int          numErrors = 0, nChecks = 0;
   dpb_prefetch_buffer dpb_prefetch_buffer_i (
      .mclk(mclk), .reset_n(reset_n), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqPrefetchable(reqPrefetchable), .reqCandidateHit(reqCandidateHit), .reqAddr(reqAddr),
      .l2Disabled(l2Disabled), .l2SizeZero(l2SizeZero), .l2Frozen(l2Frozen), .permitWrite(permitWrite),
      .permitRegion(permitRegion), .permitValue(permitValue), .hitData(hitData), .hitWait(hitWait),
      .forwardMiss(forwardMiss), .hitEntry(hitEntry), .hitHalf(hitHalf), .pfValid(pfValid), .pfReady(pfReady),
      .pfAddr(pfAddr), .pfTag(pfTag), .pfWholeLine(pfWholeLine), .rtnValid(rtnValid), .rtnTag(rtnTag),
      .rtnOk(rtnOk), .serveValid(serveValid), .serveEntry(serveEntry), .serveHalf(serveHalf));
   dpb_mem_model dpb_mem_model_i (.mclk(mclk), .reset_n(reset_n), .stall(stall), .hold(hold), .fail(fail),
      .pfValid(pfValid), .pfReady(pfReady), .pfTag(pfTag), .rtnValid(rtnValid), .rtnTag(rtnTag), .rtnOk(rtnOk));
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      if (pfValid && pfReady) begin
         qAddr.push_back(pfAddr);
         qTag.push_back(pfTag);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      nChecks++;
      if (ok !== 1'b1) begin
         numErrors++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask
   task automatic req(input logic w, input logic p, input logic c, input logic [31:0] a);
      @(posedge mclk);
      reqWrite <= w;
      reqPrefetchable <= p;
      reqCandidateHit <= c;
      reqAddr <= a;
      reqValid <= 1'b1;
      @(negedge mclk);
      fl = {hitData, hitWait, forwardMiss, hitHalf};
      ent = hitEntry;
      @(posedge mclk);
      reqValid <= 1'b0;
   endtask
   task automatic waitq(input int n);
      for (int k = 0; k < 50 && qTag.size() < n; k++) @(posedge mclk);
      if (qTag.size() < n) begin
         chk(1'b0, "prefetch timeout");
         end_of_test();
      end
   endtask
   task automatic alloc(input logic [31:0] a);
      qAddr.delete();
      qTag.delete();
      req(1'b0, 1'b1, 1'b1, a);
      waitq(2);
      chk(qAddr[0] === a + 32'h0000_0080 && qTag[0][0] === 1'b0, "first prefetch");
      chk(qAddr[1] === a + 32'h0000_00C0 && qTag[1] === {qTag[0][3:1], 1'b1}, "second prefetch");
   endtask
   task automatic set_permit(input logic [7:0] r, input logic v);
      @(posedge mclk);
      permitWrite <= 1'b1;
      permitRegion <= r;
      permitValue <= v;
      @(posedge mclk);
      permitWrite <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         alloc(32'h0C00_0000 + 32'(i) * 32'h0000_1000);
         e[i] = qTag[0][3:1];
      end
      for (int i = 1; i < 8; i++)
         for (int j = 0; j < i; j++) chk(e[i] !== e[j], "entry reused early");
      chk(e[8] === e[0], "oldest not reused");
      $display("alloc test done");
      req(1'b0, 1'b0, 1'b0, 32'h0C00_10C0);
      chk(fl === 4'b1001 && ent === e[1], "upper half hit");
      req(1'b0, 1'b0, 1'b0, 32'h0C00_1080);
      chk(fl === 4'b1000 && ent === e[1], "lower half hit");
      req(1'b1, 1'b0, 1'b0, 32'h0C00_10C0);
      req(1'b0, 1'b0, 1'b0, 32'h0C00_10C0);
      chk(fl[3:1] === 3'b001, "written half still hits");
      req(1'b0, 1'b0, 1'b0, 32'h0B00_0000);
      chk(fl[3:1] === 3'b001, "miss not forwarded");
      $display("hit test done");
      qTag.delete();
      req(1'b0, 1'b1, 1'b1, 32'h0B00_2000);
      set_permit(8'h0C, 1'b0);
      req(1'b0, 1'b1, 1'b1, 32'h0C00_3000);
      repeat (4) @(posedge mclk);
      chk(qTag.size() == 0, "prefetch in closed region");
      set_permit(8'h20, 1'b1);
      alloc(32'h2000_0000);
      set_permit(8'h0C, 1'b1);
      $display("permit test done");
      @(posedge mclk);
      stall <= 1'b1;
      hold <= 1'b1;
      qAddr.delete();
      qTag.delete();
      req(1'b0, 1'b1, 1'b1, 32'h0C00_A000);
      repeat (3) @(posedge mclk);
      chk(pfValid === 1'b1 && pfAddr === 32'h0C00_A0C0 && pfTag[0] === 1'b1 && qTag.size() == 0, "stalled prefetch");
      stall <= 1'b0;
      waitq(1);
      req(1'b0, 1'b0, 1'b0, 32'h0C00_A0C0);
      chk(fl === 4'b0101 && ent === qTag[0][3:1], "wait hit");
      hold <= 1'b0;
      for (int k = 0; k < 20 && serveValid !== 1'b1; k++) @(negedge mclk);
      chk(serveValid === 1'b1 && serveEntry === qTag[0][3:1] && serveHalf === 1'b1, "serve");
      $display("serve test done");
      @(posedge mclk);
      fail <= 1'b1;
      alloc(32'h0C00_B000);
      repeat (3) @(posedge mclk);
      fail <= 1'b0;
      req(1'b0, 1'b0, 1'b0, 32'h0C00_B080);
      chk(fl[3:1] === 3'b001, "failed slot not a miss");
      $display("fail test done");
      @(posedge mclk);
      l2Frozen <= 1'b1;
      qAddr.delete();
      qTag.delete();
      req(1'b0, 1'b1, 1'b0, 32'h0C00_B080);
      waitq(1);
      chk(qAddr[0] === 32'h0C00_B0C0 && qTag[0] === {ent, 1'b1}, "lookback prefetch");
      $display("lookback test done");
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {l2Disabled, l2SizeZero, l2Frozen} <= (i == 3) ? 3'h0 : 3'h1 << i;
         @(negedge mclk);
         chk(pfWholeLine === (i == 3), "line mode");
      end
      $display("l2 mode test done");
      end_of_test();
   end
endmodule
